// File: core/uerr_first_bit.sv
// priority picker: lowest set bit of a 32-bit vector
// purely combinational, used for the capture index
`timescale 1ns/1ps
module uerr_first_bit
  import uerr_pkg::*;
(
  // vector in
  input wire logic [31:0] vec,
  // result
  output logic found,
  output logic [4:0] index
);
  always_comb begin
    found = 1'b0;
    index = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule

// File: core/uerr_mask_bank.sv
// uncorrectable-error status, mask and severity registers with capture and report gating
// assumes error events arrive as synchronous one-cycle pulses on clk
// assumes the register port never raises both strobes in one cycle
// Functional notes
// - mask bit 0 set stops a link training error from header capture and from an error message.
// - mask bit 4 set stops a data link protocol error from capture and from an error message.
// - mask bit 12 set stops a poisoned packet, received or generated, from capture and messaging.
// - mask bit 13 set stops a flow control protocol error from capture and messaging.
// - mask bit 14 set stops a completion timeout from capture and messaging.
// - mask bit 15 set stops a completer abort from capture and messaging.
// - mask bit 16 set stops an unexpected completion from capture and messaging.
// - mask bit 17 set stops a receive buffer overflow from capture and messaging.
// - mask bit 18 set stops a malformed packet from capture and messaging.
// - mask bit 19 set stops an end-to-end CRC failure from capture and messaging.
// - mask bit 20 set stops an unsupported request from capture and messaging.
// - status bits set on every event regardless of mask and clear when software writes a one.
`timescale 1ns/1ps
module uerr_mask_bank
  import uerr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // error events, one bit per class
  input wire logic [31:0] err_event,
  // capture request toward the header log
  output logic capture_valid,
  output logic [4:0] capture_index,
  // error message request toward the root complex
  output logic report_valid,
  output logic report_fatal,
  output logic [4:0] report_index,
  // interrupt
  output logic irq
);
  // register port carrier
  reg_req_t req;

  // capture and report strobes
  err_event_t capture_evt;
  err_event_t report_evt;
  err_event_t next_capture_evt;
  err_event_t next_report_evt;

  // mask and severity
  logic [31:0] suppress;
  logic [31:0] next_suppress;
  logic [31:0] fatality;
  logic [31:0] next_fatality;

  // error status
  logic [31:0] status;
  logic [31:0] next_status;

  // interrupt
  logic [1:0] irq_status;
  logic [1:0] next_irq_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic next_irq;

  // read data
  logic [31:0] next_rdata;

  // gated events and the picker result
  logic [31:0] events;
  logic [31:0] passed;
  logic pick_found;
  logic [4:0] pick_index;

  // event counters
  logic [7:0] capture_count;
  logic [7:0] next_capture_count;
  logic [7:0] report_count;
  logic [7:0] next_report_count;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign events = err_event & defined_bits;

  // a set mask bit blocks both the header capture and the message
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gate
      assign passed[g] = events[g] & ~suppress[g];
    end
  endgenerate

  // lowest class wins when several arrive together; the rest still set status
  uerr_first_bit picker (
    .vec(passed),
    .found(pick_found),
    .index(pick_index)
  );

  // write decode, one hit per register
  logic wr_suppress;
  logic wr_fatality;
  logic wr_status;
  logic wr_irq_status;
  logic wr_irq_mask;

  assign wr_suppress = req.wr && (req.addr == uerr_suppress_offset);
  assign wr_fatality = req.wr && (req.addr == uerr_fatality_offset);
  assign wr_status = req.wr && (req.addr == uerr_status_offset);
  assign wr_irq_status = req.wr && (req.addr == irq_status_offset);
  assign wr_irq_mask = req.wr && (req.addr == irq_mask_offset);

  // mask: reserved bits are preserved, only defined ones take the write
  always_comb begin
    next_suppress = suppress;
    if (wr_suppress) begin
      next_suppress = (suppress & reserved_preserved) | (req.wdata & defined_bits);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      suppress <= suppress_reset;
    end else begin
      suppress <= next_suppress;
    end
  end

  // severity: same preservation as the mask, only steers report_fatal
  always_comb begin
    next_fatality = fatality;
    if (wr_fatality) begin
      next_fatality = (fatality & reserved_preserved) | (req.wdata & defined_bits);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fatality <= fatality_reset;
    end else begin
      fatality <= next_fatality;
    end
  end

  // status: set after clear so a same-cycle event is never lost
  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status = status & ~(req.wdata & defined_bits);
    end
    // masked events still land here; the mask only gates capture and message
    next_status = next_status | events;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= status_reset;
    end else begin
      status <= next_status;
    end
  end

  // interrupt enables
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_irq_mask) begin
      next_irq_mask = req.wdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask <= irq_reset;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // interrupt status: both causes follow the picker, set wins over the clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_irq_status) begin
      next_irq_status = irq_status & ~req.wdata[1:0];
    end
    next_irq_status[irq_capture_bit] = next_irq_status[irq_capture_bit] | pick_found;
    next_irq_status[irq_report_bit] = next_irq_status[irq_report_bit] | pick_found;
    // taken from next values so irq rises with the status flop, not a cycle later
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= irq_reset;
      irq <= irq_line_reset;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  // capture strobe: lowest unmasked class of this cycle
  always_comb begin
    next_capture_evt = '{valid: pick_found, index: pick_index, fatal: fatality[pick_index]};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_evt <= '0;
    end else begin
      capture_evt <= next_capture_evt;
    end
  end

  // message request: same class as the capture, so header log and message agree
  always_comb begin
    next_report_evt = '{valid: pick_found, index: pick_index, fatal: fatality[pick_index]};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      report_evt <= '0;
    end else begin
      report_evt <= next_report_evt;
    end
  end

  // capture counter, 8 bits, wraps without notice
  always_comb begin
    next_capture_count = capture_count + 8'(pick_found);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_count <= count_reset;
    end else begin
      capture_count <= next_capture_count;
    end
  end

  // message counter, kept apart so a later split of the two paths stays visible
  always_comb begin
    next_report_count = report_count + 8'(pick_found);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      report_count <= count_reset;
    end else begin
      report_count <= next_report_count;
    end
  end

  // read path, one cycle latency; idle cycles and unmapped addresses read zero
  always_comb begin
    next_rdata = rdata_reset;
    if (req.rd) begin
      case (req.addr)
        uerr_status_offset: begin
          next_rdata = status;
        end
        uerr_suppress_offset: begin
          next_rdata = suppress;
        end
        uerr_fatality_offset: begin
          next_rdata = fatality;
        end
        irq_status_offset: begin
          next_rdata = {30'h0, irq_status};
        end
        irq_mask_offset: begin
          next_rdata = {30'h0, irq_mask};
        end
        capture_offset: begin
          next_rdata = {24'h000000, capture_count};
        end
        report_offset: begin
          next_rdata = {24'h000000, report_count};
        end
        default: begin
          next_rdata = rdata_reset;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= rdata_reset;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  assign capture_valid = capture_evt.valid;
  assign capture_index = capture_evt.index;
  assign report_valid = report_evt.valid;
  assign report_index = report_evt.index;
  assign report_fatal = report_evt.fatal;
endmodule

// File: core/uerr_pkg.sv
// package: register map, field layout and carriers for the uncorrectable_error_suppress block
// assumes a single 20 MHz core clock and a plain register port
package uerr_pkg;
  localparam logic [11:0] uerr_status_offset = 12'h104;
  localparam logic [11:0] uerr_suppress_offset = 12'h108;
  localparam logic [11:0] uerr_fatality_offset = 12'h10C;
  localparam logic [11:0] irq_status_offset = 12'h200;
  localparam logic [11:0] irq_mask_offset = 12'h204;
  localparam logic [11:0] capture_offset = 12'h208;
  localparam logic [11:0] report_offset = 12'h20C;
  // error class positions
  localparam int training_bit = 0;
  localparam int dl_protocol_bit = 4;
  localparam int poisoned_bit = 12;
  localparam int flow_ctrl_bit = 13;
  localparam int cpl_timeout_bit = 14;
  localparam int cpl_abort_bit = 15;
  localparam int unexp_cpl_bit = 16;
  localparam int rx_overflow_bit = 17;
  localparam int malformed_bit = 18;
  localparam int ecrc_bit = 19;
  localparam int unsup_req_bit = 20;
  localparam int acs_bit = 21;
  localparam logic [31:0] defined_bits = 32'h003FF011;
  localparam logic [31:0] reserved_preserved = ~defined_bits;
  localparam logic [31:0] suppress_reset = 32'h00000000;
  localparam logic [31:0] status_reset = 32'h00000000;
  localparam logic [31:0] fatality_reset = 32'h00000000;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam logic irq_line_reset = 1'b0;
  localparam logic [7:0] count_reset = 8'h00;
  localparam logic [31:0] rdata_reset = 32'h00000000;
  localparam int irq_capture_bit = 0;
  localparam int irq_report_bit = 1;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] index;
    logic fatal;
  } err_event_t;
endpackage

// File: test/tb_uncorrectable_error_suppress.sv
// testbench: register port, per-class masking, status, interrupt and message path
// assumes the bank, its checker and the root model are compiled first
`timescale 1ns/1ps
module tb_uncorrectable_error_suppress;
  import uerr_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, err_event = 32'h0, reg_rdata;
  logic capture_valid, report_valid, report_fatal, irq;
  logic [4:0] capture_index, report_index;
  logic [7:0] msg_count;
  logic [5:0] last_msg;
  int errors = 0, compares = 0;
  int cls[12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
  always #25 clk = ~clk;
  uerr_mask_bank dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .err_event,
    .capture_valid, .capture_index, .report_valid, .report_fatal, .report_index, .irq);
  uerr_root_model rc_u (.clk, .sys_rst, .report_valid, .report_fatal, .report_index, .msg_count, .last_msg);
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", reg_rdata, exp);
  endtask
  // one-cycle event, pulses looked at in the cycle they stand
  task automatic ev(logic [31:0] bits, logic cap, logic [4:0] idx, logic fat);
    @(posedge clk);
    err_event <= bits;
    @(posedge clk);
    err_event <= 32'h0;
    @(negedge clk);
    chk("capture_report", {capture_valid, report_valid}, {cap, cap});
    if (cap) chk("index_fatal", {capture_index, report_index, report_fatal}, {idx, idx, fat});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(uerr_suppress_offset, 32'h0);
    wr(uerr_suppress_offset, 32'hFFFFFFFF);
    rd(uerr_suppress_offset, defined_bits);
    foreach (cls[i]) begin
      wr(uerr_suppress_offset, 32'hFFFFFFFF);
      ev(32'h1 << cls[i], 1'b0, 5'h0, 1'b0);
      rd(uerr_status_offset, 32'h1 << cls[i]);
      wr(uerr_suppress_offset, defined_bits ^ (32'h1 << cls[i]));
      ev(32'h1 << cls[i], 1'b1, 5'(cls[i]), 1'b0);
      wr(uerr_status_offset, 32'hFFFFFFFF);
      rd(uerr_status_offset, 32'h0);
    end
    chk("irq_masked", irq, 1'b0);
    rd(capture_offset, 32'hC);
    chk("messages", msg_count, 8'hC);
    wr(irq_mask_offset, 32'h3);
    repeat (2) @(negedge clk);
    chk("irq_on", irq, 1'b1);
    wr(irq_status_offset, 32'h3);
    repeat (2) @(negedge clk);
    chk("irq_off", irq, 1'b0);
    wr(uerr_suppress_offset, 32'h0);
    wr(uerr_fatality_offset, 32'h4000);
    ev(32'h00304000, 1'b1, 5'h0E, 1'b1);
    rd(12'h300, 32'h0);
    chk("last_message", last_msg, {1'b1, 5'h0E});
    // mid-run reset with the mask full and status bits still set
    wr(uerr_suppress_offset, 32'hFFFFFFFF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(uerr_suppress_offset, 32'h0);
    rd(uerr_status_offset, 32'h0);
    conclude();
  end
  initial begin
    #1000000;
    errors++;
    conclude();
  end
endmodule

// File: test/uerr_mask_bank_properties.sv
// checker: port-level relations of the uncorrectable_error_suppress bank
// assumes it is bound onto uerr_mask_bank and sees only its ports
`timescale 1ns/1ps
module uerr_mask_bank_properties
  import uerr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // error events
  input wire logic [31:0] err_event,
  // capture and report
  input wire logic capture_valid,
  input wire logic [4:0] capture_index,
  input wire logic report_valid,
  input wire logic report_fatal,
  input wire logic [4:0] report_index,
  // interrupt
  input wire logic irq
);
  logic [31:0] smask;
  logic [31:0] next_smask;
  // shadow mask rebuilt from port writes, reserved bits dropped
  always_comb begin
    next_smask = smask;
    if (reg_wr && reg_addr == uerr_suppress_offset) next_smask = reg_wdata & defined_bits;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) smask <= 32'h0;
    else smask <= next_smask;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_mask_read; $past(reg_rd && reg_addr == uerr_suppress_offset) |-> reg_rdata == $past(smask); endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
  property p_masked; capture_valid |-> (($past(smask) >> capture_index) & 32'h1) == 32'h0; endproperty
  a_masked: assert property (p_masked) else $error("masked class captured");
  property p_unmasked; |($past(err_event) & ~$past(smask) & defined_bits) |-> capture_valid; endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked event lost");
  property p_hit; capture_valid |-> (($past(err_event) >> capture_index) & 32'h1) == 32'h1; endproperty
  a_hit: assert property (p_hit) else $error("capture without its event");
  property p_pair; capture_valid |-> report_valid && report_index == capture_index; endproperty
  a_pair: assert property (p_pair) else $error("capture without report");
  property p_rep_only; report_valid |-> capture_valid; endproperty
  a_rep_only: assert property (p_rep_only) else $error("report without capture");
  property p_defined; capture_valid |-> defined_bits[capture_index]; endproperty
  a_defined: assert property (p_defined) else $error("capture of reserved class");
endmodule

bind uerr_mask_bank uerr_mask_bank_properties props_u (.clk, .sys_rst, .reg_wr, .reg_rd, .capture_valid,
  .report_valid, .report_fatal, .irq, .reg_addr, .reg_wdata, .reg_rdata, .err_event, .capture_index, .report_index);

// File: test/uerr_root_model.sv
// root complex stand-in: counts error messages and keeps the last one
// assumes one-cycle report pulses synchronous to clk
`timescale 1ns/1ps
module uerr_root_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // message request from the port
  input wire logic report_valid,
  input wire logic report_fatal,
  input wire logic [4:0] report_index,
  // what has arrived
  output logic [7:0] msg_count,
  output logic [5:0] last_msg
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_count <= 8'h00;
      last_msg <= 6'h00;
    end else if (report_valid) begin
      msg_count <= msg_count + 8'h01;
      last_msg <= {report_fatal, report_index};
    end
  end
endmodule
